// >>> logic/dcb_pkg.sv
package dcb_pkg;
  // array geometry
  localparam int BANKS = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 14;
  localparam int COL_W = 4;
  localparam int DATA_W = 16;
  localparam int MASK_W = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int TMR_W = 8;
  // address bit that flags auto precharge or precharge-all
  localparam int AP_BIT = 10;
  // mode register fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_REG_RST = 14'h0000;
  localparam logic [ADDR_W-1:0] EXT_MODE_REG_RST = 14'h0000;
  // mode register select codes on the bank inputs
  localparam logic [BA_W-1:0] MR_SEL_BASE = 2'h0;
  localparam logic [BA_W-1:0] MR_SEL_EXT = 2'h1;
  // clock rate and internal operation times
  localparam int CLK_MHZ = 100;
  localparam int ACT_TIME_NS = 20;
  localparam int PRE_TIME_NS = 20;
  localparam int REF_TIME_NS = 120;
  localparam int MRS_TIME_NS = 15;
  localparam int SREF_PERIOD_NS = 1000;
  // least times rounded up to whole cycles
  localparam int ACT_CYC = (ACT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PRE_CYC = (PRE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int REF_CYC = (REF_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int MRS_CYC = (MRS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SREF_CYC = (SREF_PERIOD_NS * CLK_MHZ + 999) / 1000;

  // decoded command
  typedef enum {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_MRS} dcb_cmd_t;
  // per bank state
  typedef enum logic [2:0] {BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE, BK_READ_AP,
                BK_WRITE_AP, BK_PRECHARGING} dcb_bank_st_t;
  // device wide state
  typedef enum logic [2:0] {DEV_RUN, DEV_REFRESH, DEV_MRS, DEV_PD_PRE, DEV_PD_ACT,
                DEV_SELF_REF} dcb_dev_st_t;

  // command bus pins, sampled on each rising edge
  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic cke;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dcb_pins_t;

  // one write data element with its byte mask
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [MASK_W-1:0] write_byte_mask;
  } dcb_wr_word_t;
endpackage

// >>> logic/dcb_top.sv
// Functional notes
// - decode CS RAS CAS WE each edge
// - deselect and nop identical, start nothing
// - activate takes bank and row address
// - read/write take bank, column, A10 autoprecharge
// - precharge one bank, or all when A10
// - refresh with CKE high, self refresh low
// - refresh uses internal counter, ignores inputs
// - MRS bank code selects base or extended
// - masked write elements leave storage unchanged
// - action from CKE history, state, command
// - idle bank takes activate; refresh, MRS all-idle
// - active bank takes read, write, precharge
// - read burst: read, terminate, precharge allowed
// - write burst: read, write, precharge allowed
`timescale 1ns/10ps

// small word fifo in the write data path
module dcb_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // fill side
  input wire logic [W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // drain side
  output logic [W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem_r [D]; // storage
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt; // fill pointer
  logic [PW-1:0] rd_ptr_r, rd_ptr_nxt; // drain pointer
  logic [PW:0] cnt_r, cnt_nxt; // occupancy
  logic rdy_r, rdy_nxt; // registered not-full
  logic push, pop;

  // pointer and count update
  always_comb begin
    push = in_valid_in && rdy_r;
    pop = out_ready_in && (cnt_r != '0);
    wr_ptr_nxt = push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = pop ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (PW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (PW+1)'(cnt_r - 1'b1);
    end
    rdy_nxt = (cnt_nxt != (PW+1)'(D));
  end

  // registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // data storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  assign in_ready_out = rdy_r;
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rd_ptr_r];
endmodule

// command decode, bank state and burst engine
module dcb_top import dcb_pkg::*; (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // command bus, same clock as the controller
  input wire dcb_pins_t cmd_pins_in,
  // write data stream
  input wire dcb_wr_word_t wr_word_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  // read data stream
  output logic [DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  // status
  output dcb_dev_st_t dev_state_out,
  output dcb_bank_st_t bank_state_out [BANKS],
  output logic [ADDR_W-1:0] mode_reg_out,
  output logic [ADDR_W-1:0] ext_mode_reg_out,
  output logic [BA_W+ADDR_W-1:0] refresh_addr_out,
  output logic illegal_out
);
  // reset release
  logic rst_q1_r, rst_q2_r;
  logic rst_b;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_q1_r <= 1'b0;
      rst_q2_r <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_q2_r <= rst_q1_r;
    end
  end
  assign rst_b = rst_q2_r;

  // state
  dcb_bank_st_t bank_st_r [BANKS], bank_st_nxt [BANKS]; // per bank state
  logic [ADDR_W-1:0] bank_row_r [BANKS], bank_row_nxt [BANKS]; // open row
  logic [TMR_W-1:0] bank_tmr_r [BANKS], bank_tmr_nxt [BANKS]; // busy countdown
  dcb_dev_st_t dev_st_r, dev_st_nxt; // device state
  logic [TMR_W-1:0] dev_tmr_r, dev_tmr_nxt; // refresh/mrs countdown
  logic cke_prev_r, cke_prev_nxt; // clock enable at last edge
  logic [ADDR_W-1:0] mr_r, mr_nxt; // base mode register
  logic [ADDR_W-1:0] emr_r, emr_nxt; // extended mode register
  logic [BA_W+ADDR_W-1:0] ref_cnt_r, ref_cnt_nxt; // refresh bank/row
  logic bst_act_r, bst_act_nxt; // burst running
  logic bst_wr_r, bst_wr_nxt; // burst is a write
  logic [BA_W-1:0] bst_bank_r, bst_bank_nxt; // burst bank
  logic [COL_W-1:0] bst_col_r, bst_col_nxt; // start column
  logic [2:0] bst_idx_r, bst_idx_nxt; // element index
  logic [3:0] bst_len_r, bst_len_nxt; // burst length
  logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic illegal_r, illegal_nxt; // sticky, cleared by reset only
  logic [DATA_W-1:0] mem_r [BANKS << COL_W]; // storage array

  // combinational helpers
  dcb_cmd_t cmd; // decoded command
  logic all_idle;
  logic run; // command edge with cke high twice
  logic cut; // command ends the running burst
  logic step; // burst advances this edge
  logic pop; // take a write element
  logic mem_we;
  logic [BA_W+COL_W-1:0] mem_addr;
  logic [COL_W-1:0] cmask;
  logic [COL_W-1:0] low;
  logic [BA_W-1:0] ba;
  dcb_wr_word_t fifo_word;
  logic fifo_valid;

  // write data fifo
  dcb_fifo #(
    .W($bits(dcb_wr_word_t)),
    .D(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_in(clk_sys_in),
    .rst_b_in(rst_b),
    .in_data_in(wr_word_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .out_data_out(fifo_word),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop)
  );

  // burst length from mode register code
  function automatic logic [3:0] bl_len(input logic [2:0] code);
    logic [3:0] len;
    len = 4'h2;
    case (code)
      BL_CODE_4: len = 4'h4;
      BL_CODE_8: len = 4'h8;
      default: len = 4'h2;
    endcase
    return len;
  endfunction

  // command decode
  always_comb begin
    cmd = CMD_NOP;
    if (!cmd_pins_in.cs_b) begin
      case ({cmd_pins_in.ras_b, cmd_pins_in.cas_b, cmd_pins_in.we_b})
        3'h3: cmd = CMD_ACT;
        3'h5: cmd = CMD_RD;
        3'h4: cmd = CMD_WR;
        3'h6: cmd = CMD_BST;
        3'h2: cmd = CMD_PRE;
        3'h1: cmd = CMD_REF;
        3'h0: cmd = CMD_MRS;
        default: cmd = CMD_NOP; // encoded nop
      endcase
    end
  end

  // next state of banks, device and burst
  always_comb begin
    bank_st_nxt = bank_st_r;
    bank_row_nxt = bank_row_r;
    bank_tmr_nxt = bank_tmr_r;
    dev_st_nxt = dev_st_r;
    dev_tmr_nxt = dev_tmr_r;
    cke_prev_nxt = cmd_pins_in.cke; // sampled every edge
    mr_nxt = mr_r;
    emr_nxt = emr_r;
    ref_cnt_nxt = ref_cnt_r;
    bst_act_nxt = bst_act_r;
    bst_wr_nxt = bst_wr_r;
    bst_bank_nxt = bst_bank_r;
    bst_col_nxt = bst_col_r;
    bst_idx_nxt = bst_idx_r;
    bst_len_nxt = bst_len_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    illegal_nxt = illegal_r;
    ba = cmd_pins_in.ba;
    all_idle = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      if (bank_st_r[i] != BK_IDLE) begin
        all_idle = 1'b0;
      end
    end
    // timed bank transitions
    for (int i = 0; i < BANKS; i++) begin
      if (bank_tmr_r[i] != '0) begin
        bank_tmr_nxt[i] = TMR_W'(bank_tmr_r[i] - 1'b1);
        if (bank_tmr_r[i] == TMR_W'(1)) begin
          bank_st_nxt[i] = (bank_st_r[i] == BK_ACTIVATING) ? BK_ACTIVE : BK_IDLE;
        end
      end
    end
    // edge with cke high now and before: commands act
    run = (dev_st_r == DEV_RUN) && cmd_pins_in.cke && cke_prev_r;
    // burst column, wrapping within the burst block
    cmask = COL_W'(bst_len_r - 1'b1);
    low = mr_r[MR_BT_BIT] ? (bst_col_r ^ COL_W'(bst_idx_r))
                          : COL_W'(bst_col_r + COL_W'(bst_idx_r));
    mem_addr = {bst_bank_r, (bst_col_r & ~cmask) | (low & cmask)};
    // burst step in run state only: write also waits for data, read does not
    pop = bst_act_r && bst_wr_r && fifo_valid && (dev_st_r == DEV_RUN);
    step = bst_act_r && (dev_st_r == DEV_RUN) && (!bst_wr_r || fifo_valid);
    mem_we = pop;
    if (step && !bst_wr_r) begin
      rd_data_nxt = mem_r[mem_addr];
      rd_valid_nxt = 1'b1;
    end
    if (step) begin
      bst_idx_nxt = 3'(bst_idx_r + 1'b1);
    end
    cut = run && bst_act_r &&
          ((cmd == CMD_BST) || (cmd == CMD_RD) || (cmd == CMD_WR) ||
           ((cmd == CMD_PRE) && (cmd_pins_in.addr[AP_BIT] || ba == bst_bank_r)));
    // burst ends: naturally on last element, or cut by a command
    if (cut || (step && ({1'b0, bst_idx_r} == 4'(bst_len_r - 1'b1)))) begin
      bst_act_nxt = 1'b0;
      case (bank_st_r[bst_bank_r])
        BK_READ, BK_WRITE: bank_st_nxt[bst_bank_r] = BK_ACTIVE;
        BK_READ_AP, BK_WRITE_AP: begin // auto precharge closes the row
          bank_st_nxt[bst_bank_r] = BK_PRECHARGING;
          bank_tmr_nxt[bst_bank_r] = TMR_W'(PRE_CYC);
        end
        default: bank_st_nxt[bst_bank_r] = bank_st_r[bst_bank_r];
      endcase
    end
    case (dev_st_r)
      DEV_RUN: begin
        if (!cmd_pins_in.cke && cke_prev_r) begin // cke falling
          if (cmd == CMD_REF && all_idle) begin
            dev_st_nxt = DEV_SELF_REF;
            dev_tmr_nxt = TMR_W'(SREF_CYC);
          end else if (cmd == CMD_NOP) begin
            dev_st_nxt = all_idle ? DEV_PD_PRE : DEV_PD_ACT;
          end else begin
            illegal_nxt = 1'b1;
          end
        end else if (run) begin
          case (cmd)
            CMD_ACT: begin
              if (bank_st_r[ba] == BK_IDLE) begin
                bank_st_nxt[ba] = BK_ACTIVATING;
                bank_row_nxt[ba] = cmd_pins_in.addr;
                bank_tmr_nxt[ba] = TMR_W'(ACT_CYC);
              end else begin
                illegal_nxt = 1'b1;
              end
            end
            CMD_RD, CMD_WR: begin
              if (bank_st_r[ba] == BK_ACTIVE || bank_st_r[ba] == BK_WRITE ||
                  (bank_st_r[ba] == BK_READ && cmd == CMD_RD)) begin
                if (cmd_pins_in.addr[AP_BIT]) begin
                  bank_st_nxt[ba] = (cmd == CMD_RD) ? BK_READ_AP : BK_WRITE_AP;
                end else begin
                  bank_st_nxt[ba] = (cmd == CMD_RD) ? BK_READ : BK_WRITE;
                end
                bst_act_nxt = 1'b1;
                bst_wr_nxt = (cmd == CMD_WR);
                bst_bank_nxt = ba;
                bst_col_nxt = cmd_pins_in.addr[COL_W-1:0];
                bst_idx_nxt = 3'h0;
                bst_len_nxt = bl_len(mr_r[MR_BL_LSB +: 3]);
              end else begin
                illegal_nxt = 1'b1;
              end
            end
            CMD_BST: begin
              if (!(bst_act_r && bank_st_r[bst_bank_r] == BK_READ)) begin
                illegal_nxt = 1'b1; // undefined use
              end
            end
            CMD_PRE: begin
              for (int i = 0; i < BANKS; i++) begin
                if (cmd_pins_in.addr[AP_BIT] || ba == BA_W'(i)) begin
                  if (bank_st_r[i] == BK_ACTIVE || bank_st_r[i] == BK_READ ||
                      bank_st_r[i] == BK_WRITE) begin
                    bank_st_nxt[i] = BK_PRECHARGING;
                    bank_tmr_nxt[i] = TMR_W'(PRE_CYC);
                  end else if (bank_st_r[i] != BK_IDLE) begin
                    illegal_nxt = 1'b1;
                  end
                end
              end
            end
            CMD_REF: begin
              if (all_idle) begin
                dev_st_nxt = DEV_REFRESH;
                dev_tmr_nxt = TMR_W'(REF_CYC);
                ref_cnt_nxt = (BA_W+ADDR_W)'(ref_cnt_r + 1'b1);
              end else begin
                illegal_nxt = 1'b1;
              end
            end
            CMD_MRS: begin
              if (all_idle) begin
                dev_st_nxt = DEV_MRS;
                dev_tmr_nxt = TMR_W'(MRS_CYC);
                if (ba == MR_SEL_BASE) begin
                  mr_nxt = cmd_pins_in.addr;
                end else if (ba == MR_SEL_EXT) begin
                  emr_nxt = cmd_pins_in.addr;
                end else begin
                  illegal_nxt = 1'b1; // reserved select
                end
              end else begin
                illegal_nxt = 1'b1;
              end
            end
            default: begin // deselect or nop: nothing new
            end
          endcase
        end
      end
      DEV_REFRESH, DEV_MRS: begin // inputs ignored until done
        dev_tmr_nxt = TMR_W'(dev_tmr_r - 1'b1);
        if (dev_tmr_r == TMR_W'(1)) begin
          dev_st_nxt = DEV_RUN;
        end
      end
      DEV_PD_PRE, DEV_PD_ACT: begin
        if (cmd_pins_in.cke) begin // exit on cke rise
          dev_st_nxt = DEV_RUN;
          if (cmd != CMD_NOP) begin
            illegal_nxt = 1'b1;
          end
        end
      end
      DEV_SELF_REF: begin
        // periodic internal refresh
        dev_tmr_nxt = TMR_W'(dev_tmr_r - 1'b1);
        if (dev_tmr_r == TMR_W'(1)) begin
          dev_tmr_nxt = TMR_W'(SREF_CYC);
          ref_cnt_nxt = (BA_W+ADDR_W)'(ref_cnt_r + 1'b1);
        end
        if (cmd_pins_in.cke) begin // exit
          dev_st_nxt = DEV_RUN;
          if (cmd != CMD_NOP) begin
            illegal_nxt = 1'b1;
          end
        end
      end
      default: dev_st_nxt = DEV_RUN;
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys_in or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_st_r[i] <= BK_IDLE;
        bank_row_r[i] <= '0;
        bank_tmr_r[i] <= '0;
      end
      dev_st_r <= DEV_RUN;
      dev_tmr_r <= '0;
      cke_prev_r <= 1'b0;
      mr_r <= MODE_REG_RST;
      emr_r <= EXT_MODE_REG_RST;
      ref_cnt_r <= '0;
      bst_act_r <= 1'b0;
      bst_wr_r <= 1'b0;
      bst_bank_r <= '0;
      bst_col_r <= '0;
      bst_idx_r <= '0;
      bst_len_r <= 4'h2;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      bank_st_r <= bank_st_nxt;
      bank_row_r <= bank_row_nxt;
      bank_tmr_r <= bank_tmr_nxt;
      dev_st_r <= dev_st_nxt;
      dev_tmr_r <= dev_tmr_nxt;
      cke_prev_r <= cke_prev_nxt;
      mr_r <= mr_nxt;
      emr_r <= emr_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      bst_act_r <= bst_act_nxt;
      bst_wr_r <= bst_wr_nxt;
      bst_bank_r <= bst_bank_nxt;
      bst_col_r <= bst_col_nxt;
      bst_idx_r <= bst_idx_nxt;
      bst_len_r <= bst_len_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // storage write, masked byte lanes keep their value
  always_ff @(posedge clk_sys_in) begin
    if (mem_we) begin
      for (int b = 0; b < MASK_W; b++) begin
        if (!fifo_word.write_byte_mask[b]) begin
          mem_r[mem_addr][b*8 +: 8] <= fifo_word.data[b*8 +: 8];
        end
      end
    end
  end

  // outputs
  assign rd_data_out = rd_data_r;
  assign rd_valid_out = rd_valid_r;
  assign dev_state_out = dev_st_r;
  assign bank_state_out = bank_st_r;
  assign mode_reg_out = mr_r;
  assign ext_mode_reg_out = emr_r;
  assign refresh_addr_out = ref_cnt_r;
  assign illegal_out = illegal_r;
endmodule

// >>> verif/dcb_ctrl_model.sv
`timescale 1ns/10ps
// controller side of the command bus, driving just after falling edges
module dcb_ctrl_model import dcb_pkg::*; (
  // clock
  input wire logic clk_in,
  // command bus toward the device
  output dcb_pins_t pins_out
);
  // power-up: deselected, clock enable low
  initial begin
    pins_out = {4'hf, 1'b0, {(BA_W + ADDR_W){1'b1}}};
  end

  // idle cycles; address lines wander so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_in);
      pins_out.addr = ADDR_W'($urandom);
    end
  endtask

  // one command for one edge, then back to nop; clock enable level persists
  task automatic issue(input logic [3:0] c, input logic [BA_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic k);
    @(negedge clk_in);
    {pins_out.cs_b, pins_out.ras_b, pins_out.cas_b, pins_out.we_b} = c;
    pins_out.ba = b;
    pins_out.addr = a;
    pins_out.cke = k;
    @(negedge clk_in);
    {pins_out.cs_b, pins_out.ras_b, pins_out.cas_b, pins_out.we_b} = 4'h7;
    pins_out.ba = ~b;
  endtask
endmodule

// >>> verif/dcb_top_asserts.sv
`timescale 1ns/10ps
// command to state relations seen at the top ports
module dcb_top_asserts import dcb_pkg::*; (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // command bus and status
  input wire dcb_pins_t cmd_pins_in,
  input wire dcb_dev_st_t dev_state_out,
  input wire dcb_bank_st_t bank_state_out [BANKS],
  input wire logic [ADDR_W-1:0] mode_reg_out,
  input wire logic [ADDR_W-1:0] ext_mode_reg_out
);
  // copy of the reset release and clock enable history
  logic [1:0] sync_r;
  logic ckep_r;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_r <= 2'h0;
      ckep_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[0], 1'b1};
      ckep_r <= sync_r[1] & cmd_pins_in.cke;
    end
  end
  // decoded pins
  wire [3:0] c = {cmd_pins_in.cs_b, cmd_pins_in.ras_b, cmd_pins_in.cas_b, cmd_pins_in.we_b};
  wire [BA_W-1:0] ba = cmd_pins_in.ba;
  wire ap = cmd_pins_in.addr[AP_BIT];
  wire nop = c[3] || c == 4'h7;
  wire run = sync_r[1] && dev_state_out == DEV_RUN && ckep_r;
  wire go = run && cmd_pins_in.cke;
  wire idle = bank_state_out[0] == BK_IDLE && bank_state_out[1] == BK_IDLE &&
              bank_state_out[2] == BK_IDLE && bank_state_out[3] == BK_IDLE;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!sync_r[1]);

  a_act_opens_bank:
    assert property (go && c == 4'h3 && bank_state_out[ba] == BK_IDLE
      |=> bank_state_out[$past(ba)] == BK_ACTIVATING) else $error("activate ignored");
  a_read_starts_burst:
    assert property (go && c == 4'h5 && bank_state_out[ba] == BK_ACTIVE
      |=> bank_state_out[$past(ba)] == ($past(ap) ? BK_READ_AP : BK_READ))
      else $error("read state wrong");
  a_write_starts_burst:
    assert property (go && c == 4'h4 && bank_state_out[ba] == BK_ACTIVE
      |=> bank_state_out[$past(ba)] == ($past(ap) ? BK_WRITE_AP : BK_WRITE))
      else $error("write state wrong");
  a_pre_one_bank:
    assert property (go && c == 4'h2 && !ap && bank_state_out[ba] == BK_ACTIVE
      |=> bank_state_out[$past(ba)] == BK_PRECHARGING) else $error("precharge ignored");
  a_pre_all_banks:
    assert property (go && c == 4'h2 && ap |=> bank_state_out[0] != BK_ACTIVE &&
      bank_state_out[1] != BK_ACTIVE && bank_state_out[2] != BK_ACTIVE &&
      bank_state_out[3] != BK_ACTIVE) else $error("bank left open");
  a_nop_starts_nothing:
    assert property (go && nop && idle |=> idle && dev_state_out == DEV_RUN)
      else $error("nop changed state");
  a_refresh_runs_out:
    assert property (go && c == 4'h1 && idle |=> (dev_state_out == DEV_REFRESH) [*8]
      ##[1:8] dev_state_out == DEV_RUN) else $error("refresh timing wrong");
  a_self_ref_entry:
    assert property (run && !cmd_pins_in.cke && c == 4'h1 && idle
      |=> dev_state_out == DEV_SELF_REF) else $error("no self refresh");
  a_pd_entry_kind:
    assert property (run && !cmd_pins_in.cke && nop
      |=> dev_state_out == ($past(idle) ? DEV_PD_PRE : DEV_PD_ACT))
      else $error("power-down kind wrong");
  a_pd_holds_low:
    assert property ((dev_state_out == DEV_PD_PRE || dev_state_out == DEV_PD_ACT)
      && !cmd_pins_in.cke |=> $stable(dev_state_out)) else $error("power-down left");
  a_mrs_loads_reg:
    assert property (go && c == 4'h0 && idle && (ba == MR_SEL_BASE || ba == MR_SEL_EXT)
      |=> ($past(ba) == MR_SEL_BASE ? mode_reg_out : ext_mode_reg_out)
      == $past(cmd_pins_in.addr)) else $error("mode register not loaded");
endmodule

bind dcb_top dcb_top_asserts i_dcb_top_asserts (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cmd_pins_in(cmd_pins_in),
  .dev_state_out(dev_state_out), .bank_state_out(bank_state_out),
  .mode_reg_out(mode_reg_out), .ext_mode_reg_out(ext_mode_reg_out)
);

// >>> verif/tb_ddr_command_decode_bank_state.sv
`timescale 1ns/10ps
module tb_ddr_command_decode_bank_state import dcb_pkg::*; ;
  // design-facing signals
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  dcb_pins_t pins;
  dcb_wr_word_t wr_word_in = '0;
  logic wr_valid_in = 1'b0;
  logic wr_ready_out, rd_valid_out, illegal_out;
  logic [DATA_W-1:0] rd_data_out;
  dcb_dev_st_t dev_state_out;
  dcb_bank_st_t bank_state_out [BANKS];
  logic [ADDR_W-1:0] mode_reg_out, ext_mode_reg_out;
  logic [BA_W+ADDR_W-1:0] refresh_addr_out;
  // bookkeeping
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  logic [1:0] b;
  logic [BA_W+ADDR_W-1:0] ref_old;
  dcb_wr_word_t w1 [4], w2 [4];
  logic [DATA_W-1:0] got [$];
  // command codes cs ras cas we
  localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, BST = 4'h6;
  localparam logic [3:0] PRE = 4'h2, REF = 4'h1, MRS = 4'h0, NOP = 4'h7;

  always #5 clk_sys_in = ~clk_sys_in;
  // hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  dcb_ctrl_model i_dcb_ctrl_model (.clk_in(clk_sys_in), .pins_out(pins));
  dcb_top i_dcb_top (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cmd_pins_in(pins),
    .wr_word_in(wr_word_in), .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .dev_state_out(dev_state_out),
    .bank_state_out(bank_state_out), .mode_reg_out(mode_reg_out),
    .ext_mode_reg_out(ext_mode_reg_out), .refresh_addr_out(refresh_addr_out),
    .illegal_out(illegal_out));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [13:0] a,
                     input logic k = 1'b1);
    i_dcb_ctrl_model.issue(c, ba, a, k);
  endtask
  task automatic nop(input int n);
    i_dcb_ctrl_model.idle(n);
  endtask
  // offer one word, held until taken
  task automatic push(input dcb_wr_word_t w);
    @(negedge clk_sys_in);
    wr_word_in = w;
    wr_valid_in = 1'b1;
    while (wr_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(posedge clk_sys_in);
  endtask
  // four words fill the buffer, the fifth is refused
  task automatic fill(input dcb_wr_word_t w [4]);
    foreach (w[i]) push(w[i]);
    @(negedge clk_sys_in);
    chk(wr_ready_out === 1'b0, "buffer took a fifth word");
    wr_valid_in = 1'b0;
  endtask
  // gather read elements over a window
  task automatic collect(input int n);
    got.delete();
    repeat (n) begin
      if (rd_valid_out === 1'b1) got.push_back(rd_data_out);
      @(negedge clk_sys_in);
    end
  endtask
  // stored value after a masked write over an older one
  function automatic logic [DATA_W-1:0] merge(input dcb_wr_word_t o, input dcb_wr_word_t w);
    merge = w.data;
    for (int i = 0; i < MASK_W; i++)
      if (w.write_byte_mask[i]) merge[8*i +: 8] = o.data[8*i +: 8];
  endfunction

  initial begin
    void'($urandom(32'h909a));
    b = 2'($urandom);
    foreach (w1[i]) begin
      w1[i] = {16'($urandom), 2'h0};
      w2[i] = {16'($urandom), 2'($urandom)};
    end
    w2[0].write_byte_mask = 2'h3;
    repeat (8) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    cmd(NOP, 2'h0, 14'h0);
    nop(4);
    chk(dev_state_out === DEV_RUN && illegal_out === 1'b0 && mode_reg_out === 14'h0, "reset");
    foreach (bank_state_out[i]) chk(bank_state_out[i] === BK_IDLE, "bank after reset");
    cmd({1'b1, 3'($urandom)}, b, 14'($urandom));
    chk(bank_state_out[b] === BK_IDLE && dev_state_out === DEV_RUN, "deselect acted");
    cmd(MRS, MR_SEL_EXT, 14'h0001);
    nop(MRS_CYC + 1);
    cmd(MRS, MR_SEL_BASE, 14'h000a);
    chk(dev_state_out === DEV_MRS, "mode register access");
    nop(MRS_CYC + 1);
    chk(mode_reg_out === 14'h000a && ext_mode_reg_out === 14'h0001, "mode regs");
    cmd(ACT, b, 14'($urandom));
    chk(bank_state_out[b] === BK_ACTIVATING, "activate");
    nop(ACT_CYC + 1);
    chk(bank_state_out[b] === BK_ACTIVE, "row not open");
    fill(w1);
    cmd(WR, b, 14'h0);
    chk(bank_state_out[b] === BK_WRITE, "write burst");
    nop(6);
    fill(w2);
    cmd(WR, b, 14'h0);
    nop(6);
    cmd(RD, b, 14'h0401);
    chk(bank_state_out[b] === BK_READ_AP, "auto precharge read");
    collect(10);
    chk(got.size() == 4, "read burst length");
    foreach (got[i]) chk(got[i] === merge(w1[i ^ 1], w2[i ^ 1]), "masked data");
    nop(3);
    chk(bank_state_out[b] === BK_IDLE, "auto precharge");
    cmd(ACT, b, 14'h0);
    nop(ACT_CYC + 1);
    cmd(RD, b, 14'h0);
    cmd(BST, 2'($urandom), 14'h0);
    collect(8);
    chk(got.size() < 4 && bank_state_out[b] === BK_ACTIVE, "burst terminate");
    cmd(ACT, b ^ 2'h1, 14'h0);
    nop(ACT_CYC + 1);
    cmd(PRE, b, 14'h0);
    chk(bank_state_out[b] === BK_PRECHARGING && bank_state_out[b ^ 2'h1] === BK_ACTIVE,
        "single precharge");
    nop(PRE_CYC + 1);
    cmd(NOP, 2'h0, 14'h0, 1'b0);
    chk(dev_state_out === DEV_PD_ACT, "active power-down");
    nop(5);
    chk(dev_state_out === DEV_PD_ACT, "power-down held");
    cmd(NOP, 2'h0, 14'h0, 1'b1);
    nop(2);
    chk(dev_state_out === DEV_RUN && bank_state_out[b ^ 2'h1] === BK_ACTIVE, "pd exit");
    cmd(ACT, b, 14'h0);
    nop(ACT_CYC + 1);
    cmd(PRE, 2'($urandom), 14'h0400);
    nop(PRE_CYC + 1);
    foreach (bank_state_out[i]) chk(bank_state_out[i] === BK_IDLE, "precharge all");
    cmd(NOP, 2'h0, 14'h0, 1'b0);
    chk(dev_state_out === DEV_PD_PRE, "precharge power-down");
    cmd(NOP, 2'h0, 14'h0, 1'b1);
    nop(2);
    ref_old = refresh_addr_out;
    cmd(REF, 2'($urandom), 14'($urandom));
    chk(dev_state_out === DEV_REFRESH, "auto refresh");
    nop(REF_CYC + 1);
    chk(dev_state_out === DEV_RUN && refresh_addr_out !== ref_old, "refresh counter");
    ref_old = refresh_addr_out;
    cmd(REF, 2'h0, 14'h0, 1'b0);
    chk(dev_state_out === DEV_SELF_REF, "self refresh entry");
    nop(SREF_CYC + 10);
    chk(dev_state_out === DEV_SELF_REF && refresh_addr_out !== ref_old, "self ref");
    cmd(NOP, 2'h0, 14'h0, 1'b1);
    nop(200);
    chk(dev_state_out === DEV_RUN, "self refresh exit");
    cmd(RD, b, 14'h0);
    nop(1);
    chk(bank_state_out[b] === BK_IDLE && illegal_out === 1'b1, "read to idle bank");
    rst_b_in = 1'b0;
    nop(2);
    chk(illegal_out === 1'b0 && dev_state_out === DEV_RUN, "reinit after illegal");
    report_and_stop();
  end
endmodule
